// *** rtl/fps_defs.svh ***
// How it works
// RQ1: Program: code 40h/10h, then address plus data
// RQ2: After program/erase setup, reads return status
// RQ3: Host polls status until b7 reports ready
// RQ4: Status b4 alone means program failure
// RQ5: LPC only: b1 flags protected block target
// RQ6: Status b3 flags invalid programming supply
// RQ7: Host clears status after error before next operation
// RQ8: Quad program: four consecutive addresses, A1:A0 only (host issues single-byte program only)
// RQ9: Erase: code 20h, then D0h at block
// RQ10: b4 and b5 together mean sequence error
// RQ11: b5 alone means block erase failure
// RQ12: Reset taken in 100ns idle, 30us active
// RQ13: Reset pin held low at least 100ns
// RQ14: LPC: wait 30us after reset release
// RQ15: Muxed: wait 50us after reset release
// RQ16: Write-locked block rejects program/erase, flags status
// RQ17: Erase without confirm code gives sequence error
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

`define FPS_AW            21
`define FPS_BLK_W         16
`define FPS_PROG_CYC      250
`define FPS_ERASE_CYC     1000

`define FPS_CMD_PROG_A    8'h40
`define FPS_CMD_PROG_B    8'h10
`define FPS_CMD_ERASE     8'h20
`define FPS_CMD_CONFIRM   8'hD0
`define FPS_CMD_CLR       8'h50
`define FPS_CMD_RD_STAT   8'h70
`define FPS_CMD_RD_ARRAY  8'hFF
`define FPS_ARRAY_DATA    8'hFF

`define FPS_SR_READY      7
`define FPS_SR_ERASE      5
`define FPS_SR_PROG       4
`define FPS_SR_VPP        3
`define FPS_SR_PROT       1

`define FPS_CLK_NS        40
`define FPS_T_PULSE_NS    100
`define FPS_T_IDLE_RST_NS 100
`define FPS_T_ACT_RST_NS  30000
`define FPS_T_LPC_WAIT_NS 30000
`define FPS_T_MUX_WAIT_NS 50000
`define FPS_PULSE_CYC     ((`FPS_T_PULSE_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_IDLE_RST_CYC  (`FPS_T_IDLE_RST_NS / `FPS_CLK_NS)
`define FPS_ACT_RST_CYC   (`FPS_T_ACT_RST_NS / `FPS_CLK_NS)
`define FPS_LPC_WAIT_CYC  ((`FPS_T_LPC_WAIT_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_MUX_WAIT_CYC  ((`FPS_T_MUX_WAIT_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)

`define FPS_OFF_CTRL      8'h00
`define FPS_OFF_ADDR      8'h04
`define FPS_OFF_DATA      8'h08
`define FPS_OFF_STAT      8'h0C
`define FPS_OFF_ISTAT     8'h10
`define FPS_OFF_ICLR      8'h14
`define FPS_OFF_IEN       8'h18

`define FPS_CTRL_PROG     0
`define FPS_CTRL_ERASE    1
`define FPS_CTRL_RESET    2
`define FPS_CTRL_LPC      3

`endif

// *** rtl/fps_pkg.sv ***
package fps_pkg;
    typedef enum logic [2:0] {
        D_READY,
        D_PSETUP,
        D_ESETUP,
        D_BUSY
    } fps_dev_fsm_t;

    typedef enum logic [2:0] {
        H_RLOW,
        H_RWAIT,
        H_IDLE,
        H_CLR,
        H_C1,
        H_C2,
        H_POLL
    } fps_host_fsm_t;
endpackage

// *** rtl/fps_if.sv ***
`timescale 1ns/1ns
`include "fps_defs.svh"
interface fps_if #(parameter int AW = `FPS_AW);
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;
    logic          ack;
    logic          reset_pin_n;
    logic          lpc_sel;
    logic          ready_busy_out;

    modport dev (input wr, rd, addr, wdata, reset_pin_n, lpc_sel,
                 output rdata, ack, ready_busy_out);
    modport host (output wr, rd, addr, wdata, reset_pin_n, lpc_sel,
                  input rdata, ack, ready_busy_out);
endinterface

// *** rtl/fps_timer.sv ***
`timescale 1ns/1ns
module fps_timer #(
    parameter int          W    = 16,
    parameter logic [15:0] INIT = 16'h0000
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         load,
    input  wire logic [W-1:0] val,
    output logic              zero
);
    logic [W-1:0] cnt_reg;

    if (W < 2 || W > 16) begin : g_chk
        $error("fps_timer: W out of range");
    end

    assign zero = (cnt_reg == '0);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= INIT[W-1:0];
        end else if (load) begin
            cnt_reg <= val;
        end else if (!zero) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule

// *** rtl/fps_device.sv ***
`timescale 1ns/1ns
`include "fps_defs.svh"
module fps_device import fps_pkg::*; #(
    parameter int AW        = `FPS_AW,
    parameter int BW        = `FPS_BLK_W,
    parameter int PROG_CYC  = `FPS_PROG_CYC,
    parameter int ERASE_CYC = `FPS_ERASE_CYC
) (
    input  wire logic          REF_CLK,
    input  wire logic          NRST,
    fps_if.dev                 BUS,
    input  wire logic          VPP_OK,
    input  wire logic          PROG_FAIL,
    input  wire logic          ERASE_FAIL,
    input  wire logic          LOCK_WE,
    input  wire logic [AW-BW-1:0] LOCK_BLK,
    input  wire logic          LOCK_SET,
    output logic               IN_RESET
);
    localparam int NB = 1 << (AW - BW);

    if (AW <= BW || PROG_CYC < 1 || PROG_CYC > 65535 || ERASE_CYC < 1
        || ERASE_CYC > 65535) begin : g_chk
        $error("fps_device: bad parameters");
    end

    fps_dev_fsm_t  fsm_reg;
    logic [7:0]    sr_reg;
    logic          stat_mode_reg;
    logic          ack_reg;
    logic [7:0]    rdata_reg;
    logic [3:0]    low_cnt_reg;
    logic [NB-1:0] lock_reg;
    logic          erase_reg;

    wire           take    = (BUS.wr | BUS.rd) & ~ack_reg & ~IN_RESET;
    wire           wtake   = take & BUS.wr;
    wire [7:0]     cmd     = BUS.wdata;
    wire           locked  = lock_reg[BUS.addr[AW-1:BW]];
    wire           busy    = (fsm_reg == D_BUSY);
    wire           tmr_zero;
    wire           start;
    wire           op_done = busy & tmr_zero & ~start;
    wire [2:0]     err_bit = erase_reg ? 3'(`FPS_SR_ERASE) : 3'(`FPS_SR_PROG);
    wire           pstart  = wtake & (fsm_reg == D_PSETUP);
    wire           estart  = wtake & (fsm_reg == D_ESETUP) & (cmd == `FPS_CMD_CONFIRM);
    wire           refused = ~VPP_OK | locked;

    assign start              = (pstart | estart) & ~refused;
    assign BUS.ack            = ack_reg;
    assign BUS.rdata          = rdata_reg;
    assign BUS.ready_busy_out = ~busy;
    assign IN_RESET           = (low_cnt_reg == 4'(`FPS_IDLE_RST_CYC));

    fps_timer #(.W(16), .INIT(16'h0000)) u_tmr (
        .clk  (REF_CLK),
        .nrst (NRST),
        .load (start),
        .val  (estart ? 16'(ERASE_CYC) : 16'(PROG_CYC)),
        .zero (tmr_zero)
    );

    // Pin must stay low for the full count; reset aborts any operation at once
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            low_cnt_reg <= 4'h0;
        end else if (BUS.reset_pin_n) begin
            low_cnt_reg <= 4'h0;
        end else if (!IN_RESET) begin
            low_cnt_reg <= low_cnt_reg + 4'h1; // RQ12
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ack_reg <= take;
            if (take) begin
                rdata_reg <= stat_mode_reg ? {~busy, sr_reg[6:0]} : `FPS_ARRAY_DATA; // RQ2
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            lock_reg <= '1;
        end else if (IN_RESET) begin
            lock_reg <= '1;
        end else if (LOCK_WE) begin
            lock_reg[LOCK_BLK] <= LOCK_SET;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            fsm_reg       <= D_READY;
            sr_reg        <= 8'h00;
            stat_mode_reg <= 1'b0;
            erase_reg     <= 1'b0;
        end else if (IN_RESET) begin
            fsm_reg       <= D_READY; // RQ12
            sr_reg        <= 8'h00;
            stat_mode_reg <= 1'b0;
        end else begin
            case (fsm_reg)
                D_READY: begin
                    if (wtake) begin
                        case (cmd)
                            `FPS_CMD_PROG_A, `FPS_CMD_PROG_B: begin
                                fsm_reg       <= D_PSETUP; // RQ1
                                stat_mode_reg <= 1'b1; // RQ2
                                erase_reg     <= 1'b0;
                            end
                            `FPS_CMD_ERASE: begin
                                fsm_reg       <= D_ESETUP; // RQ9
                                stat_mode_reg <= 1'b1; // RQ2
                                erase_reg     <= 1'b1;
                            end
                            `FPS_CMD_CLR:      sr_reg <= 8'h00;
                            `FPS_CMD_RD_STAT:  stat_mode_reg <= 1'b1;
                            `FPS_CMD_RD_ARRAY: stat_mode_reg <= 1'b0;
                            default: ;
                        endcase
                    end
                end
                D_PSETUP, D_ESETUP: begin
                    if (wtake) begin
                        fsm_reg <= start ? D_BUSY : D_READY;
                        if (fsm_reg == D_ESETUP && cmd != `FPS_CMD_CONFIRM) begin
                            sr_reg[`FPS_SR_PROG]  <= 1'b1; // RQ17
                            sr_reg[`FPS_SR_ERASE] <= 1'b1; // RQ10
                        end else if (!VPP_OK) begin
                            sr_reg[`FPS_SR_VPP] <= 1'b1; // RQ6
                        end else if (locked && BUS.lpc_sel) begin
                            sr_reg[`FPS_SR_PROT] <= 1'b1; // RQ5
                        end else if (locked) begin
                            sr_reg[err_bit] <= 1'b1; // RQ16
                        end
                    end
                end
                D_BUSY: begin
                    if (op_done) begin
                        fsm_reg <= D_READY;
                        if (erase_reg && ERASE_FAIL) begin
                            sr_reg[`FPS_SR_ERASE] <= 1'b1; // RQ11
                        end
                        if (!erase_reg && PROG_FAIL) begin
                            sr_reg[`FPS_SR_PROG] <= 1'b1; // RQ4
                        end
                    end
                end
                default: fsm_reg <= D_READY;
            endcase
        end
    end
endmodule

// *** rtl/fps_host.sv ***
`timescale 1ns/1ns
`include "fps_defs.svh"
module fps_host import fps_pkg::*; #(
    parameter int AW = `FPS_AW
) (
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ,
    fps_if.host              BUS
);
    if (AW < 2 || AW > 32) begin : g_chk
        $error("fps_host: AW out of range");
    end

    fps_host_fsm_t fsm_reg;
    logic          wr_reg;
    logic          rd_reg;
    logic [AW-1:0] baddr_reg;
    logic [7:0]    bdata_reg;
    logic          rpin_reg;
    logic          lpc_reg;
    logic          erase_reg;
    logic [AW-1:0] addr_reg;
    logic [7:0]    data_reg;
    logic [7:0]    sbyte_reg;
    logic [4:0]    err_reg;
    logic [1:0]    istat_reg;
    logic [1:0]    ien_reg;
    logic [31:0]   prdata_reg;
    logic          pslverr_reg;

    wire        setup   = PSEL & ~PENABLE;
    wire        apb_wr  = PSEL & PENABLE & PWRITE;
    wire        hit_ctl = (PADDR == `FPS_OFF_CTRL);
    wire        go_prog = apb_wr & hit_ctl & PWDATA[`FPS_CTRL_PROG];
    wire        go_ers  = apb_wr & hit_ctl & PWDATA[`FPS_CTRL_ERASE];
    wire        go_rst  = apb_wr & hit_ctl & PWDATA[`FPS_CTRL_RESET];
    wire        idle    = (fsm_reg == H_IDLE);
    wire        go      = idle & (go_prog | go_ers);
    wire        rst_ok  = (fsm_reg != H_RLOW) & (fsm_reg != H_RWAIT);
    wire        rst_go  = rst_ok & go_rst & ~go;
    wire        tmr_zero;
    wire        tmr_load;
    wire [15:0] tmr_val;
    wire [7:0]  sr      = BUS.rdata;
    wire        fin     = (fsm_reg == H_POLL) & BUS.ack & sr[`FPS_SR_READY]; // RQ3
    wire [4:0]  err_new;
    wire [1:0]  ev_set;
    wire        mapped;
    wire [31:0] rd_mux;
    wire [7:0]  first_cmd;

    // Error word: {prot, vpp, seq, erase, prog}
    assign err_new[0] = sr[`FPS_SR_PROG] & ~sr[`FPS_SR_ERASE]; // RQ4
    assign err_new[1] = sr[`FPS_SR_ERASE] & ~sr[`FPS_SR_PROG]; // RQ11
    assign err_new[2] = sr[`FPS_SR_PROG] & sr[`FPS_SR_ERASE]; // RQ10
    assign err_new[3] = sr[`FPS_SR_VPP]; // RQ6
    assign err_new[4] = sr[`FPS_SR_PROT] & lpc_reg; // RQ5

    assign ev_set    = {fin & (|err_new), fin};
    assign first_cmd = erase_reg ? `FPS_CMD_ERASE : `FPS_CMD_PROG_A;

    // Reset pulse length and the settle wait after release
    assign tmr_load = rst_go | ((fsm_reg == H_RLOW) & tmr_zero);
    assign tmr_val  = (fsm_reg == H_RLOW)
                    ? (lpc_reg ? 16'(`FPS_LPC_WAIT_CYC) : 16'(`FPS_MUX_WAIT_CYC)) // RQ14 RQ15
                    : 16'(`FPS_PULSE_CYC); // RQ13

    fps_timer #(.W(16), .INIT(16'(`FPS_PULSE_CYC))) u_tmr (
        .clk  (REF_CLK),
        .nrst (NRST),
        .load (tmr_load),
        .val  (tmr_val),
        .zero (tmr_zero)
    );

    assign BUS.wr          = wr_reg;
    assign BUS.rd          = rd_reg;
    assign BUS.addr        = baddr_reg;
    assign BUS.wdata       = bdata_reg;
    assign BUS.reset_pin_n = rpin_reg;
    assign BUS.lpc_sel     = lpc_reg;

    assign mapped = (PADDR == `FPS_OFF_CTRL) | (PADDR == `FPS_OFF_ADDR)
                  | (PADDR == `FPS_OFF_DATA) | (PADDR == `FPS_OFF_STAT)
                  | (PADDR == `FPS_OFF_ISTAT) | (PADDR == `FPS_OFF_ICLR)
                  | (PADDR == `FPS_OFF_IEN);

    assign rd_mux =
        (PADDR == `FPS_OFF_CTRL)  ? {28'h0000000, lpc_reg, 3'h0} :
        (PADDR == `FPS_OFF_ADDR)  ? 32'(addr_reg) :
        (PADDR == `FPS_OFF_DATA)  ? {24'h000000, data_reg} :
        (PADDR == `FPS_OFF_STAT)  ? {16'h0000, sbyte_reg, 2'h0, err_reg, ~idle} :
        (PADDR == `FPS_OFF_ISTAT) ? {30'h0, istat_reg} :
        (PADDR == `FPS_OFF_IEN)   ? {30'h0, ien_reg} :
        32'h00000000;

    assign PREADY  = 1'b1;
    assign PRDATA  = prdata_reg;
    assign PSLVERR = pslverr_reg;
    assign IRQ     = |(istat_reg & ien_reg);

    // Read data is latched in the setup cycle so it is stable in access
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= PWRITE ? 32'h00000000 : rd_mux;
            pslverr_reg <= ~mapped;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            lpc_reg  <= 1'b0;
            addr_reg <= '0;
            data_reg <= 8'h00;
            ien_reg  <= 2'h0;
        end else if (apb_wr) begin
            if (hit_ctl) begin
                lpc_reg <= PWDATA[`FPS_CTRL_LPC];
            end
            if (PADDR == `FPS_OFF_ADDR) begin
                addr_reg <= PWDATA[AW-1:0];
            end
            if (PADDR == `FPS_OFF_DATA) begin
                data_reg <= PWDATA[7:0];
            end
            if (PADDR == `FPS_OFF_IEN) begin
                ien_reg <= PWDATA[1:0];
            end
        end
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            istat_reg <= 2'h0;
        end else if (apb_wr && PADDR == `FPS_OFF_ICLR) begin
            istat_reg <= (istat_reg & ~PWDATA[1:0]) | ev_set;
        end else begin
            istat_reg <= istat_reg | ev_set;
        end
    end

    // Requests are held until ack; a reset request aborts any operation, but in H_IDLE a start written with it wins and the reset is dropped
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            fsm_reg   <= H_RLOW;
            rpin_reg  <= 1'b0;
            wr_reg    <= 1'b0;
            rd_reg    <= 1'b0;
            baddr_reg <= '0;
            bdata_reg <= 8'h00;
            erase_reg <= 1'b0;
            sbyte_reg <= 8'h00;
            err_reg   <= 5'h00;
        end else if (rst_go) begin
            rpin_reg <= 1'b0;
            wr_reg   <= 1'b0;
            rd_reg   <= 1'b0;
            fsm_reg  <= H_RLOW;
        end else begin
            case (fsm_reg)
                H_RLOW: begin
                    if (tmr_zero) begin
                        rpin_reg <= 1'b1; // RQ13
                        fsm_reg  <= H_RWAIT;
                    end
                end
                H_RWAIT: begin
                    if (tmr_zero) begin
                        fsm_reg <= H_IDLE; // RQ14 RQ15
                    end
                end
                H_IDLE: begin
                    if (go) begin
                        // Single-byte program only; quad sequence is never issued
                        erase_reg <= go_ers; // RQ8
                        wr_reg    <= 1'b1;
                        baddr_reg <= addr_reg;
                        if (|err_reg) begin
                            bdata_reg <= `FPS_CMD_CLR; // RQ7
                            fsm_reg   <= H_CLR;
                        end else begin
                            bdata_reg <= go_ers ? `FPS_CMD_ERASE : `FPS_CMD_PROG_A;
                            fsm_reg   <= H_C1;
                        end
                    end
                end
                H_CLR: begin
                    if (BUS.ack) begin
                        err_reg   <= 5'h00; // RQ7
                        bdata_reg <= first_cmd;
                        fsm_reg   <= H_C1;
                    end
                end
                H_C1: begin
                    if (BUS.ack) begin
                        bdata_reg <= erase_reg ? `FPS_CMD_CONFIRM : data_reg; // RQ1 RQ9
                        fsm_reg   <= H_C2;
                    end
                end
                H_C2: begin
                    if (BUS.ack) begin
                        wr_reg  <= 1'b0;
                        rd_reg  <= 1'b1;
                        fsm_reg <= H_POLL;
                    end
                end
                H_POLL: begin
                    if (fin) begin
                        rd_reg    <= 1'b0; // RQ3
                        sbyte_reg <= sr;
                        err_reg   <= err_new;
                        fsm_reg   <= H_IDLE;
                    end
                end
                default: fsm_reg <= H_IDLE;
            endcase
        end
    end
endmodule

// *** testbench/fps_link_sva.sv ***
`timescale 1ns/1ns
module fps_link_sva #(
    parameter int AW = 21
) (
    input  wire logic          REF_CLK,
    input  wire logic          NRST,
    input  wire logic          wr,
    input  wire logic          rd,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    input  wire logic [7:0]    rdata,
    input  wire logic          ack,
    input  wire logic          reset_pin_n,
    input  wire logic          lpc_sel,
    input  wire logic          ready_busy_out
);
    localparam int BUSY_MAX = 20;
    logic [10:0] up_cnt_reg;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // Cycles since the reset pin was last released, saturating
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            up_cnt_reg <= 11'h000;
        end else if (!reset_pin_n) begin
            up_cnt_reg <= 11'h000;
        end else if (up_cnt_reg != 11'h7FF) begin
            up_cnt_reg <= up_cnt_reg + 11'h001;
        end
    end
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_req_answer;
        (wr || rd) && !ack && reset_pin_n && $past(reset_pin_n) && $past(reset_pin_n, 2) |=> ack;
    endproperty
    a_req_answer: assert property (p_req_answer)
        else $error("request not answered in one cycle");
    property p_req_hold; wr && !ack |=> wr && $stable(wdata); endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("write request dropped before ack");
    property p_prog_data; wr && ack && wdata == 8'h40 |=> wr; endproperty
    a_prog_data: assert property (p_prog_data)
        else $error("program code not followed by data");
    property p_prog_addr;
        wr && ack && (wdata == 8'h40 || wdata == 8'h10) |=> addr[AW-1:2] == $past(addr[AW-1:2]);
    endproperty
    a_prog_addr: assert property (p_prog_addr)
        else $error("program address left its word group");
    property p_erase_confirm; wr && ack && wdata == 8'h20 |=> wr && wdata == 8'hD0; endproperty
    a_erase_confirm: assert property (p_erase_confirm)
        else $error("erase setup not followed by confirm");
    property p_busy_status;
        rd && ack && !ready_busy_out && !$past(ready_busy_out) |-> !rdata[7];
    endproperty
    a_busy_status: assert property (p_busy_status)
        else $error("read while busy did not return busy status");
    property p_poll_hold; rd && ack && !rdata[7] |=> rd || !reset_pin_n; endproperty
    a_poll_hold: assert property (p_poll_hold)
        else $error("polling stopped before ready");
    property p_busy_bound; $fell(ready_busy_out) |-> ##[1:BUSY_MAX] ready_busy_out; endproperty
    a_busy_bound: assert property (p_busy_bound)
        else $error("busy too long");
    property p_reset_abort; !reset_pin_n && !$past(reset_pin_n) |-> ##[0:2] ready_busy_out; endproperty
    a_reset_abort: assert property (p_reset_abort)
        else $error("reset did not end busy in time");
    property p_reset_width; $fell(reset_pin_n) |=> !reset_pin_n [*2]; endproperty
    a_reset_width: assert property (p_reset_width)
        else $error("reset pin pulse too short");
    property p_wait_reset;
        (wr || rd) |-> up_cnt_reg >= (lpc_sel ? 11'h2EE : 11'h4E2);
    endproperty
    a_wait_reset: assert property (p_wait_reset)
        else $error("request too soon after reset pin release");
    c_prog: cover property (wr && ack && wdata == 8'h40);
    c_erase: cover property (wr && ack && wdata == 8'hD0);
    c_reset: cover property ($fell(reset_pin_n));
endmodule

// *** testbench/flash_program_erase_sequencer_bench.sv ***
`timescale 1ns/1ns
module flash_program_erase_sequencer_bench;
    logic        clk        = 1'b0;
    logic        nrst       = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic        vpp_ok     = 1'b1;
    logic        prog_fail  = 1'b0;
    logic        erase_fail = 1'b0;
    logic        lock_we    = 1'b0;
    logic [4:0]  lock_blk   = 5'h00;
    logic        lock_set   = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        in_reset;
    logic [31:0] rd_val;
    logic        rd_err;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    always #20 clk = ~clk;
    fps_if bus_if ();
    fps_host u_fps_host (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IRQ(irq), .BUS(bus_if));
    fps_device #(.PROG_CYC(5), .ERASE_CYC(8)) u_fps_device (.REF_CLK(clk), .NRST(nrst),
        .BUS(bus_if), .VPP_OK(vpp_ok), .PROG_FAIL(prog_fail), .ERASE_FAIL(erase_fail),
        .LOCK_WE(lock_we), .LOCK_BLK(lock_blk), .LOCK_SET(lock_set), .IN_RESET(in_reset));
    fps_link_sva u_fps_link_sva (.REF_CLK(clk), .NRST(nrst), .wr(bus_if.wr), .rd(bus_if.rd),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack),
        .reset_pin_n(bus_if.reset_pin_n), .lpc_sel(bus_if.lpc_sel),
        .ready_busy_out(bus_if.ready_busy_out));
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 2000; i++) begin
            apb(1'b0, 8'h0C, 32'h0);
            if (rd_val[0] === 1'b0) break;
        end
    endtask
    // Leaves the final status word in rd_val
    task automatic run_op(input logic [31:0] ctrl, input logic [20:0] a, input logic [7:0] d);
        apb(1'b1, 8'h04, {11'h000, a});
        apb(1'b1, 8'h08, {24'h000000, d});
        apb(1'b1, 8'h00, ctrl);
        wait_idle();
    endtask
    task automatic lock(input logic [4:0] b, input logic v);
        lock_blk <= b;
        lock_set <= v;
        lock_we <= 1'b1;
        @(posedge clk);
        lock_we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_regs;
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rd_err});
        chk("unmapped data", 32'h0, rd_val);
        wait_idle();
        chk("busy after reset wait", 32'h0, {31'h0, rd_val[0]});
        $display("test regs done");
    endtask
    task automatic t_prog;
        lock(5'h00, 1'b0);
        apb(1'b1, 8'h18, 32'h3);
        run_op(32'h1, 21'h000123, 8'h5A);
        chk("program status", 32'h80, {24'h0, rd_val[15:8]});
        chk("program errors", 32'h0, {27'h0, rd_val[5:1]});
        chk("irq on done", 32'h1, {31'h0, irq});
        apb(1'b1, 8'h18, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, 8'h18, 32'h3);
        apb(1'b1, 8'h14, 32'h3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test prog done");
    endtask
    task automatic t_faults;
        prog_fail <= 1'b1;
        run_op(32'h1, 21'h000200, 8'h00);
        prog_fail <= 1'b0;
        chk("program fail status", 32'h90, {24'h0, rd_val[15:8]});
        chk("program fail flag", 32'h1, {31'h0, rd_val[1]});
        apb(1'b0, 8'h10, 32'h0);
        chk("error event", 32'h1, {31'h0, rd_val[1]});
        apb(1'b1, 8'h14, 32'h3);
        erase_fail <= 1'b1;
        run_op(32'h2, 21'h000000, 8'h00);
        erase_fail <= 1'b0;
        chk("erase fail status", 32'hA0, {24'h0, rd_val[15:8]});
        chk("erase fail flag", 32'h1, {31'h0, rd_val[2]});
        vpp_ok <= 1'b0;
        run_op(32'h2, 21'h000000, 8'h00);
        vpp_ok <= 1'b1;
        chk("supply status bit", 32'h1, {31'h0, rd_val[11]});
        chk("supply flag", 32'h1, {31'h0, rd_val[4]});
        $display("test faults done");
    endtask
    task automatic t_lock;
        run_op(32'h1, 21'h010010, 8'h33);
        chk("locked program status", 32'h1, {31'h0, rd_val[12]});
        chk("no protect bit off lpc", 32'h0, {31'h0, rd_val[9]});
        run_op(32'hA, 21'h010000, 8'h00);
        chk("locked erase lpc bit", 32'h1, {31'h0, rd_val[9]});
        chk("protect flag", 32'h1, {31'h0, rd_val[5]});
        $display("test lock done");
    endtask
    task automatic t_reset;
        int i;
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'hA);
        for (i = 0; i < 20 && bus_if.ready_busy_out !== 1'b0; i++) @(posedge clk);
        chk("erase started", 32'h0, {31'h0, bus_if.ready_busy_out});
        apb(1'b1, 8'h00, 32'hC);
        for (i = 0; i < 10 && in_reset !== 1'b1; i++) @(posedge clk);
        chk("reset taken", 32'h1, {31'h0, in_reset});
        @(posedge clk);
        chk("busy aborted", 32'h1, {31'h0, bus_if.ready_busy_out});
        wait_idle();
        run_op(32'h9, 21'h000300, 8'h11);
        chk("locks set again", 32'h1, {31'h0, rd_val[9]});
        $display("test reset done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_regs();
        t_prog();
        t_faults();
        t_lock();
        t_reset();
        summarize();
    end
    initial begin
        #(40 * 40000);
        n_mismatch++;
        summarize();
    end
endmodule
